// ### design/mscan_sync.sv
// Purpose: three-stage synchroniser for a trigger pin
// Assumes: input asynchronous to pclk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
module mscan_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;
    logic       next_dout;

    always_comb
    begin
        next_dout = dout;
        if (stage[1] == stage[2])
        begin
            next_dout = stage[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage <= 3'h0;
            dout  <= 1'b0;
        end
        else
        begin
            stage <= {stage[1:0], din};
            dout  <= next_dout;
        end
    end
endmodule : mscan_sync

// ### design/mscan_top.sv
// Purpose: memory scanner feeding words from flash or EEPROM to a checksum unit
// Assumes: arbiter grants one request per cycle; memory answers with rvalid
// Notes:   APB slave, zero wait states, unmapped reads give zero with pslverr
`timescale 1ns/1ps
`include "mscan_map.svh"
module mscan_top
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`MSCAN_PADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      checksum_enable,
    input  wire logic                      checksum_go,
    input  wire logic                      crc_ready,
    input  wire logic [31:0]               trig_in,
    input  wire logic                      mem_grant,
    input  wire logic                      mem_rvalid,
    input  wire logic [`MSCAN_DATA_W-1:0]  mem_rdata,
    output logic                           mem_req,
    output logic [`MSCAN_ADDR_W-1:0]       mem_addr,
    output logic                           memory_region_select,
    output logic                           lower_hold,
    output logic                           crc_valid,
    output logic [`MSCAN_DATA_W-1:0]       crc_data,
    output logic                           irq
);
    logic                      scan_enable;
    logic                      scan_go_bit;
    logic                      trigger_pacing_enable;
    logic                      burst_mode_bit;
    logic [`MSCAN_TRIG_W-1:0]  scan_trigger_select;
    logic [`MSCAN_ADDR_W-1:0]  scan_start_address;
    logic [`MSCAN_ADDR_W-1:0]  scan_end_address;
    logic [`MSCAN_ADDR_W-1:0]  scan_current_address;
    logic                      scan_done_flag;
    logic                      irq_enable;
    mscan_pkg::mscan_state_e   state;
    logic                      trig_pending;
    logic                      trig_pulse;

    logic                      next_scan_enable;
    logic                      next_scan_go_bit;
    logic                      next_trigger_pacing_enable;
    logic                      next_burst_mode_bit;
    logic                      next_memory_region_select;
    logic [`MSCAN_TRIG_W-1:0]  next_scan_trigger_select;
    logic [`MSCAN_ADDR_W-1:0]  next_scan_start_address;
    logic [`MSCAN_ADDR_W-1:0]  next_scan_end_address;
    logic [`MSCAN_ADDR_W-1:0]  next_scan_current_address;
    logic                      next_scan_done_flag;
    logic                      next_irq_enable;
    mscan_pkg::mscan_state_e   next_state;
    logic                      next_trig_pending;
    logic                      next_mem_req;
    logic                      next_lower_hold;
    logic                      next_crc_valid;
    logic [`MSCAN_DATA_W-1:0]  next_crc_data;
    logic                      next_irq;
    logic [31:0]               next_prdata;
    logic                      next_pslverr;

    logic                      wr_en;
    logic                      rd_en;
    logic                      past_end;
    logic                      may_request;

    mscan_trig u_trig
    (
        .pclk    (pclk),
        .presetn (presetn),
        .trig_in (trig_in),
        .sel     (scan_trigger_select),
        .pulse   (trig_pulse)
    );

    // Setup phase decodes so the answer is ready at the access edge
    assign wr_en = psel & ~penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign past_end = (scan_current_address == scan_end_address);

    // Pacing gates when a fetch may start
    always_comb
    begin
        if (burst_mode_bit)
        begin
            may_request = 1'b1; // R13
        end
        else if (trigger_pacing_enable)
        begin
            may_request = trig_pending & crc_ready; // R3 R12
        end
        else
        begin
            may_request = crc_ready; // R10
        end
    end

    always_comb
    begin
        next_scan_enable           = scan_enable;
        next_scan_go_bit           = scan_go_bit;
        next_trigger_pacing_enable = trigger_pacing_enable;
        next_burst_mode_bit        = burst_mode_bit;
        next_memory_region_select  = memory_region_select;
        next_scan_trigger_select   = scan_trigger_select;
        next_scan_start_address    = scan_start_address;
        next_scan_end_address      = scan_end_address;
        next_scan_current_address  = scan_current_address;
        next_scan_done_flag        = scan_done_flag;
        next_irq_enable            = irq_enable;
        next_state                 = state;
        next_trig_pending          = trig_pending | trig_pulse;
        next_crc_valid             = 1'b0;
        next_crc_data              = crc_data;
        next_prdata                = prdata;
        next_pslverr               = 1'b0;

        if (wr_en)
        begin
            if (paddr == `MSCAN_OFS_CTRL)
            begin
                next_scan_enable           = pwdata[`MSCAN_BIT_EN];
                next_scan_go_bit           = pwdata[`MSCAN_BIT_GO];
                next_memory_region_select  = pwdata[`MSCAN_BIT_REGION]; // R2
                next_trigger_pacing_enable = pwdata[`MSCAN_BIT_TRIGGER_PACING_ENABLE];
                next_burst_mode_bit        = pwdata[`MSCAN_BIT_BURST]; // R4
                if (pwdata[`MSCAN_BIT_GO] && !scan_go_bit)
                begin
                    next_scan_current_address = scan_start_address; // R19
                    next_trig_pending         = 1'b0;
                end
            end
            else if (paddr == `MSCAN_OFS_TRIG)
            begin
                next_scan_trigger_select = pwdata[`MSCAN_TRIG_W-1:0]; // R3
            end
            else if (paddr == `MSCAN_OFS_START)
            begin
                next_scan_start_address = pwdata[`MSCAN_ADDR_W-1:0]; // R5
            end
            else if (paddr == `MSCAN_OFS_END)
            begin
                next_scan_end_address = pwdata[`MSCAN_ADDR_W-1:0]; // R5
            end
            else if (paddr == `MSCAN_OFS_CLR)
            begin
                if (pwdata[`MSCAN_BIT_DONE])
                begin
                    next_scan_done_flag = 1'b0; // R9
                end
            end
            else if (paddr == `MSCAN_OFS_IEN)
            begin
                next_irq_enable = pwdata[`MSCAN_BIT_DONE];
            end
            else if (paddr != `MSCAN_OFS_CUR && paddr != `MSCAN_OFS_STAT)
            begin
                next_pslverr = 1'b1;
            end
        end

        if (rd_en)
        begin
            next_prdata = 32'h00000000;
            if (paddr == `MSCAN_OFS_CTRL)
            begin
                next_prdata[`MSCAN_BIT_EN]     = scan_enable;
                next_prdata[`MSCAN_BIT_GO]     = scan_go_bit;
                next_prdata[`MSCAN_BIT_REGION] = memory_region_select;
                next_prdata[`MSCAN_BIT_TRIGGER_PACING_ENABLE] = trigger_pacing_enable;
                next_prdata[`MSCAN_BIT_BURST]  = burst_mode_bit;
                next_prdata[`MSCAN_BIT_BUSY]   = (state != mscan_pkg::MSCAN_IDLE);
            end
            else if (paddr == `MSCAN_OFS_TRIG)
            begin
                next_prdata[`MSCAN_TRIG_W-1:0] = scan_trigger_select;
            end
            else if (paddr == `MSCAN_OFS_START)
            begin
                next_prdata[`MSCAN_ADDR_W-1:0] = scan_start_address;
            end
            else if (paddr == `MSCAN_OFS_END)
            begin
                next_prdata[`MSCAN_ADDR_W-1:0] = scan_end_address;
            end
            else if (paddr == `MSCAN_OFS_CUR)
            begin
                next_prdata[`MSCAN_ADDR_W-1:0] = scan_current_address;
            end
            else if (paddr == `MSCAN_OFS_STAT)
            begin
                next_prdata[`MSCAN_BIT_DONE] = scan_done_flag;
            end
            else if (paddr == `MSCAN_OFS_IEN)
            begin
                next_prdata[`MSCAN_BIT_DONE] = irq_enable;
            end
            else if (paddr != `MSCAN_OFS_CLR)
            begin
                next_pslverr = 1'b1;
            end
        end

        // One word in flight, so one per transfer
        case (state)
            mscan_pkg::MSCAN_IDLE:
            begin
                // Start also needs the checksum unit running
                if (scan_go_bit && scan_enable && checksum_go && may_request) // R1 R7
                begin
                    next_state = mscan_pkg::MSCAN_REQ;
                end
            end
            mscan_pkg::MSCAN_REQ:
            begin
                if (mem_grant) // R10 R11
                begin
                    next_state        = mscan_pkg::MSCAN_FEED;
                    next_trig_pending = trig_pulse;
                end
            end
            mscan_pkg::MSCAN_FEED:
            begin
                if (mem_rvalid)
                begin
                    next_crc_valid = 1'b1; // R16
                    next_crc_data  = mem_rdata;
                    next_state     = mscan_pkg::MSCAN_IDLE;
                    if (past_end)
                    begin
                        next_scan_go_bit    = 1'b0; // R17
                        next_scan_done_flag = 1'b1; // R8
                    end
                    next_scan_current_address = scan_current_address + `MSCAN_ADDR_STEP; // R19
                end
            end
            default:
            begin
                next_state = mscan_pkg::MSCAN_IDLE;
            end
        endcase

        // Abort paths; a fetch already granted is dropped unless its word arrives in this cycle
        if (!next_scan_go_bit || !next_scan_enable || !checksum_enable)
        begin
            if (!checksum_enable || !next_scan_enable)
            begin
                next_scan_go_bit = 1'b0; // R18 R1
            end
            if (state != mscan_pkg::MSCAN_FEED || !mem_rvalid)
            begin
                next_state = mscan_pkg::MSCAN_IDLE; // R17
            end
        end

        next_mem_req    = (next_state == mscan_pkg::MSCAN_REQ); // R13
        // Burst shuts out lower requesters
        next_lower_hold = burst_mode_bit & next_scan_go_bit; // R14 R11
        next_irq        = next_scan_done_flag & next_irq_enable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_enable           <= 1'b0;
            scan_go_bit           <= 1'b0;
            trigger_pacing_enable <= 1'b0;
            burst_mode_bit        <= 1'b0;
            memory_region_select  <= 1'b0;
            scan_trigger_select   <= `MSCAN_TRIG_RST;
            scan_start_address    <= `MSCAN_ADDR_RST;
            scan_end_address      <= `MSCAN_ADDR_RST;
            scan_current_address  <= `MSCAN_ADDR_RST;
            scan_done_flag        <= 1'b0;
            irq_enable            <= 1'b0;
            state                 <= mscan_pkg::MSCAN_IDLE;
            trig_pending          <= 1'b0;
            mem_req               <= 1'b0;
            mem_addr              <= `MSCAN_ADDR_RST;
            lower_hold            <= 1'b0;
            crc_valid             <= 1'b0;
            crc_data              <= 16'h0000;
            irq                   <= 1'b0;
            prdata                <= 32'h00000000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
        end
        else
        begin
            scan_enable           <= next_scan_enable;
            scan_go_bit           <= next_scan_go_bit;
            trigger_pacing_enable <= next_trigger_pacing_enable;
            burst_mode_bit        <= next_burst_mode_bit;
            memory_region_select  <= next_memory_region_select;
            scan_trigger_select   <= next_scan_trigger_select;
            scan_start_address    <= next_scan_start_address;
            scan_end_address      <= next_scan_end_address;
            scan_current_address  <= next_scan_current_address;
            scan_done_flag        <= next_scan_done_flag;
            irq_enable            <= next_irq_enable;
            state                 <= next_state;
            trig_pending          <= next_trig_pending;
            mem_req               <= next_mem_req;
            mem_addr              <= next_scan_current_address;
            lower_hold            <= next_lower_hold;
            crc_valid             <= next_crc_valid;
            crc_data              <= next_crc_data;
            irq                   <= next_irq;
            prdata                <= next_prdata;
            pready                <= psel & ~penable;
            pslverr               <= next_pslverr;
        end
    end
endmodule : mscan_top

// ### design/mscan_trig.sv
// Purpose: synchronise trigger sources and pick the selected one
// Assumes: up to 32 asynchronous trigger lines
// Notes:   a rising edge of the selected line gives a one-cycle pulse
`timescale 1ns/1ps
`include "mscan_map.svh"
module mscan_trig
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [31:0]              trig_in,
    input  wire logic [`MSCAN_TRIG_W-1:0] sel,
    output logic                          pulse
);
    logic [31:0] synced;
    logic        prev;
    logic        next_pulse;

    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_sync
            mscan_sync u_sync
            (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (trig_in[i]),
                .dout    (synced[i])
            );
        end
    endgenerate

    always_comb
    begin
        next_pulse = synced[sel] & ~prev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev  <= 1'b0;
            pulse <= 1'b0;
        end
        else
        begin
            prev  <= synced[sel];
            pulse <= next_pulse;
        end
    end
endmodule : mscan_trig

// ### inc/mscan_map.svh
// What this block does
// R1: Scanner idle while enable is clear; CRC set up first.
// R2: Region bit picks flash or EEPROM.
// R3: Trigger select picks source; trigger enable paces scan.
// R4: Burst bit selects burst operation.
// R5: Software loads start and end addresses.
// R6: Software sets and locks arbitration priority first.
// R7: Checksum enable and go needed; go bit starts scan.
// R8: Done flag sets when address passes end.
// R9: Only a software write clears the done flag.
// R10: Unpaced scan granted only if no higher requester asks.
// R11: Outside burst, lower requesters get unused cycles.
// R12: Paced scan requests only when checksum unit ready. With burst set, the code requests without waiting for crc_ready.
// R13: Burst requests memory continuously while scanning.
// R14: Burst withholds lower requesters until go reads 0.
// R15: Pacing with burst: software keeps trigger active.
// R16: One word per transfer to the checksum unit.
// R17: Scan stops, go cleared, by software or passing end.
// R18: Clearing checksum enable clears go.
// R19: Address starts at start, one word per delivery.
//
// Purpose: register map and field positions of the memory scanner
// Assumes: APB, 32-bit data, word-aligned registers
// Notes:   addresses are 22 bits, one word each step
`ifndef MSCAN_MAP_SVH
`define MSCAN_MAP_SVH

`define MSCAN_ADDR_W       22
`define MSCAN_DATA_W       16
`define MSCAN_TRIG_W       5
`define MSCAN_PADDR_W      8

`define MSCAN_OFS_CTRL     8'h00
`define MSCAN_OFS_TRIG     8'h04
`define MSCAN_OFS_START    8'h08
`define MSCAN_OFS_END      8'h0C
`define MSCAN_OFS_CUR      8'h10
`define MSCAN_OFS_STAT     8'h14
`define MSCAN_OFS_CLR      8'h18
`define MSCAN_OFS_IEN      8'h1C

`define MSCAN_BIT_EN       0
`define MSCAN_BIT_GO       1
`define MSCAN_BIT_REGION   2
`define MSCAN_BIT_TRIGGER_PACING_ENABLE   3
`define MSCAN_BIT_BURST    4
`define MSCAN_BIT_BUSY     5
`define MSCAN_BIT_DONE     0

`define MSCAN_ADDR_STEP    22'h000001
`define MSCAN_ADDR_RST     22'h000000
`define MSCAN_TRIG_RST     5'h00

`endif

// ### inc/mscan_pkg.sv
// Purpose: types of the memory scanner
// Assumes: nothing
// Notes:   fetch sequencer states
package mscan_pkg;
    typedef enum logic [1:0]
    {
        MSCAN_IDLE = 2'b00,
        MSCAN_REQ  = 2'b01,
        MSCAN_FEED = 2'b10
    } mscan_state_e;
endpackage : mscan_pkg

// ### tb/mscan_partner.sv
// Purpose: arbiter and memory model at the scanner's far side
// Assumes: one outstanding read, data four cycles after grant
// Notes:   read data toggles while not valid so stale words are not mistaken
`timescale 1ns/1ps
`include "mscan_map.svh"
module mscan_partner
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     mem_req,
    input  wire logic [`MSCAN_ADDR_W-1:0] mem_addr,
    input  wire logic                     region,
    input  wire logic                     lower_hold,
    input  wire logic                     hi_busy,
    output logic                          mem_grant,
    output logic                          lower_gnt,
    output logic                          mem_rvalid,
    output logic [`MSCAN_DATA_W-1:0]      mem_rdata
);
    logic [1:0]                dly;
    logic                      pend;
    logic [`MSCAN_ADDR_W-1:0]  adr;

    // A higher requester wins the cycle; fixed priority stands for a locked setting
    assign mem_grant = mem_req && !hi_busy && !pend;
    assign lower_gnt = !mem_grant && !lower_hold;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pend       <= 1'b0;
            dly        <= 2'h0;
            adr        <= '0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 16'h0000;
        end
        else
        begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (mem_grant)
            begin
                pend <= 1'b1;
                dly  <= 2'h2;
                adr  <= mem_addr;
            end
            else if (pend && dly != 2'h0)
                dly <= dly - 2'h1;
            else if (pend)
            begin
                pend       <= 1'b0;
                mem_rvalid <= 1'b1;
                mem_rdata  <= adr[15:0] ^ (region ? 16'h5A5A : 16'h0000);
            end
        end
endmodule : mscan_partner

// ### tb/mscan_sva.sv
// Purpose: port checker for the memory scanner
// Assumes: partner returns memory data within a few cycles
// Notes:   bound into mscan_top at the foot of this file
`timescale 1ns/1ps
`include "mscan_map.svh"
module mscan_sva
(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [`MSCAN_PADDR_W-1:0] paddr,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      checksum_enable,
    input wire logic                      mem_req,
    input wire logic                      mem_grant,
    input wire logic [`MSCAN_ADDR_W-1:0]  mem_addr,
    input wire logic                      lower_hold,
    input wire logic                      crc_valid,
    input wire logic                      irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_grant;
        mem_req && mem_grant;
    endsequence

    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("no pready");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_UNMAPPED: assert property (s_setup ##0 (paddr > 8'h1C) |=> pslverr)
        else $error("no pslverr");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    AST_REQ_HOLD: assert property (mem_req && !mem_grant && checksum_enable && !psel
        |=> mem_req && $stable(mem_addr))
        else $error("request dropped");
    AST_FEED: assert property (s_grant |-> ##[2:20] (crc_valid || !checksum_enable))
        else $error("word lost");
    AST_VALID_PULSE: assert property (crc_valid |=> !crc_valid)
        else $error("valid too long");
    AST_ABORT: assert property (!checksum_enable [*3] |-> !mem_req && !lower_hold)
        else $error("scan not aborted");
    AST_IRQ_STICKY: assert property ($fell(irq)
        |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("flag self cleared");
endmodule : mscan_sva

bind mscan_top mscan_sva mscan_sva_i
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .checksum_enable, .mem_req, .mem_grant, .mem_addr, .lower_hold, .crc_valid, .irq
);

// ### tb/test_memory_scanner_crc_feed.sv
// Purpose: self-checking bench of the memory scanner
// Assumes: APB master at 20 MHz, partner model on the memory side
// Notes:   words are checked as they reach the checksum port
`timescale 1ns/1ps
`include "mscan_map.svh"
module test_memory_scanner_crc_feed;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, trig_in = 32'h0, rd;
    logic checksum_enable = 1'b1, checksum_go = 1'b1, crc_ready = 1'b1, hi_busy = 1'b0;
    logic pready, pslverr, mem_grant, mem_rvalid, mem_req, memory_region_select;
    logic lower_hold, crc_valid, irq, lower_gnt, er, ereg;
    logic [15:0] mem_rdata, crc_data;
    logic [21:0] mem_addr, ea;
    int n_errors = 0, n_tests = 0, n_words = 0;

    always #25 pclk = ~pclk;

    mscan_top mscan_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .checksum_enable, .checksum_go, .crc_ready, .trig_in,
        .mem_grant, .mem_rvalid, .mem_rdata, .mem_req, .mem_addr, .memory_region_select,
        .lower_hold, .crc_valid, .crc_data, .irq);
    mscan_partner mscan_partner_i (.pclk, .presetn, .mem_req, .mem_addr,
        .region(memory_region_select), .lower_hold, .hi_busy, .mem_grant, .lower_gnt,
        .mem_rvalid, .mem_rdata);

    task stop_test;
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // pready stands only in the access cycle, so it is looked at mid-cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(negedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        chk(pready === 1'b1, "no pready");
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task run(input logic [21:0] s, input logic [21:0] e, input logic [31:0] c);
        apb(1'b1, `MSCAN_OFS_CTRL, 32'h1);
        apb(1'b1, `MSCAN_OFS_START, {10'h0, s});
        apb(1'b1, `MSCAN_OFS_END, {10'h0, e});
        ea = s;
        ereg = c[2];
        n_words = 0;
        apb(1'b1, `MSCAN_OFS_CTRL, c);
    endtask : run

    task wait_done;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 500)
        begin
            @(posedge pclk);
            k++;
        end
    endtask : wait_done

    task pulse;
        trig_in <= 32'h8;
        cyc(10);
        trig_in <= 32'h0;
        cyc(10);
    endtask : pulse

    task clr;
        apb(1'b1, `MSCAN_OFS_CLR, 32'h1);
    endtask : clr

    always @(negedge pclk)
        if (crc_valid === 1'b1)
        begin
            chk(crc_data === (ea[15:0] ^ (ereg ? 16'h5A5A : 16'h0000)), "word");
            ea = ea + 22'h1;
            n_words++;
        end

    task t_regs;
        apb(1'b0, `MSCAN_OFS_CTRL, 32'h0);
        chk(rd === 32'h0, "ctrl reset");
        apb(1'b1, `MSCAN_OFS_TRIG, 32'h1F);
        apb(1'b0, `MSCAN_OFS_TRIG, 32'h0);
        chk(rd === 32'h1F, "trig readback");
        apb(1'b1, `MSCAN_OFS_CUR, 32'h55);
        apb(1'b0, `MSCAN_OFS_CUR, 32'h0);
        chk(rd === 32'h0, "cur written");
        apb(1'b0, 8'h20, 32'h0);
        chk(rd === 32'h0 && er === 1'b1, "unmapped");
        apb(1'b1, `MSCAN_OFS_IEN, 32'h1);
    endtask : t_regs

    task t_scan;
        hi_busy <= 1'b1;
        run(22'h100, 22'h103, 32'h7);
        cyc(20);
        chk(n_words === 0, "higher requester ignored");
        hi_busy <= 1'b0;
        wait_done;
        chk(irq === 1'b1 && n_words === 4, "scan count");
        apb(1'b0, `MSCAN_OFS_CUR, 32'h0);
        chk(rd === 32'h104, "end address");
        apb(1'b0, `MSCAN_OFS_CTRL, 32'h0);
        chk(rd[1] === 1'b0 && memory_region_select === 1'b1, "go or region");
        cyc(10);
        chk(irq === 1'b1, "self cleared");
        clr;
        apb(1'b0, `MSCAN_OFS_STAT, 32'h0);
        chk(rd === 32'h0 && irq === 1'b0, "not cleared");
    endtask : t_scan

    task t_disabled;
        run(22'h10, 22'h10, 32'h1);
        apb(1'b1, `MSCAN_OFS_CTRL, 32'h0);
        apb(1'b1, `MSCAN_OFS_CTRL, 32'h2);
        cyc(30);
        chk(n_words === 0 && mem_req === 1'b0, "ran while disabled");
        apb(1'b1, `MSCAN_OFS_CTRL, 32'h0);
    endtask : t_disabled

    task t_ready;
        crc_ready <= 1'b0;
        run(22'h30, 22'h30, 32'h3);
        cyc(30);
        chk(n_words === 0, "fetch while not ready");
        crc_ready <= 1'b1;
        wait_done;
        chk(n_words === 1 && irq === 1'b1, "one word");
        clr;
    endtask : t_ready

    task t_paced;
        apb(1'b1, `MSCAN_OFS_TRIG, 32'h3);
        run(22'h20, 22'h22, 32'hB);
        cyc(30);
        chk(n_words === 0, "fetch without trigger");
        pulse;
        pulse;
        chk(n_words === 2, "one word per trigger");
        pulse;
        wait_done;
        chk(irq === 1'b1, "paced end");
        clr;
    endtask : t_paced

    task t_burst;
        crc_ready <= 1'b0;
        trig_in <= 32'h8;
        run(22'h40, 22'h43, 32'h1B);
        cyc(3);
        chk(lower_hold === 1'b1 && lower_gnt === 1'b0, "lower not held");
        wait_done;
        chk(n_words === 4, "burst count");
        chk(lower_hold === 1'b0 && lower_gnt === 1'b1, "lower still held");
        crc_ready <= 1'b1;
        trig_in <= 32'h0;
        clr;
    endtask : t_burst

    task t_abort;
        int k;
        run(22'h80, 22'hFF, 32'h3);
        k = 0;
        while (n_words < 2 && k < 200)
        begin
            @(posedge pclk);
            k++;
        end
        chk(n_words >= 2, "abort start");
        checksum_enable <= 1'b0;
        cyc(5);
        apb(1'b0, `MSCAN_OFS_CTRL, 32'h0);
        chk(rd[1] === 1'b0, "go kept");
        k = n_words;
        cyc(20);
        chk(n_words === k && irq === 1'b0, "scan not ended");
        checksum_enable <= 1'b1;
    endtask : t_abort

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_scan;
        t_disabled;
        t_ready;
        t_paced;
        t_burst;
        t_abort;
        stop_test;
    end

    // A few hundred cycles needed; limit is 20000
    initial
    begin
        #1000000;
        n_errors++;
        stop_test;
    end
endmodule : test_memory_scanner_crc_feed
